// file: logic/eeprom_lock_cfg.svh
// timing, geometry and key-table constants for the eeprom lock host
`ifndef EEPROM_LOCK_CFG_SVH
`define EEPROM_LOCK_CFG_SVH
`define CLK_MHZ            20
`define READ_DELAY_US      1
`define WRITE_DELAY_5V_MS  5
`define WRITE_DELAY_3V_MS  10
`define PAGE_WINDOW_NS     100000
`define WRITE_CYCLE_US     10000
`define STROBE_CYCLES      3
`define ADDR_W             15
`define PAGE_LSB           6
`define KEY_DEPTH          8
`define KEY_IDX_W          3
`define ENABLE_KEY_LEN     3'h3
`define DISABLE_KEY_LEN    3'h6
`define DISABLE_KEY_BASE   3'h0
`define ENABLE_KEY_BASE    3'h0
`endif

// file: logic/eeprom_lock_pkg.sv
// types for the eeprom lock host
package eeprom_lock_pkg;
    typedef enum logic [1:0] {
        CMD_WRITE,
        CMD_LOCK,
        CMD_UNLOCK,
        CMD_READ
    } cmd_t;
    typedef enum {
        ST_POWERUP,
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_GAP,
        ST_READ,
        ST_PROGRAM
    } state_t;
endpackage

// file: logic/key_table.sv
// small key table memory: address and data of each key byte, registered out
`include "eeprom_lock_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module key_table #(
    parameter int IDX_W = `KEY_IDX_W
) (
    // clock
    input  wire logic               clk,
    // write port, loaded by the user before a keyed burst
    input  wire logic               wrEn,
    input  wire logic [IDX_W-1:0]   wrIdx,
    input  wire logic [22:0]        wrWord,
    // read port
    input  wire logic [IDX_W-1:0]   rdIdx,
    output logic      [22:0]        rdWord
);
    logic [22:0] mem [2**IDX_W];
    // storage and registered read
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrIdx] <= wrWord;
        end
        rdWord <= mem[rdIdx];
    end
endmodule // key_table
`default_nettype wire

// file: logic/eeprom_lock_host.sv
// host controller driving the eeprom pins for keyed lock and unlock bursts
//
// Notes on behaviour
// - Lock is one page burst of three key bytes in three pages.
// - Unlock is one page burst of six key bytes over different pages.
// - A write while locked is the enable key followed by the data byte.
// - The host waits at least 1 us after power-up before reading.
// - The host waits 5 ms (5 V) or 10 ms (3 V) before any write.
// - Data bytes of a burst share address bits 14 to 6.
// - Bytes of a burst come closer than the page-load window.
`include "eeprom_lock_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module eeprom_lock_host #(
    parameter bit LOW_VOLT     = 1'b0,
    parameter int WRITE_WAIT   = (LOW_VOLT ? `WRITE_DELAY_3V_MS
                                  : `WRITE_DELAY_5V_MS) * 1000 * `CLK_MHZ,
    parameter int PROG_WAIT    = `WRITE_CYCLE_US * `CLK_MHZ
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // key table loading
    input  wire logic                  keyWrEn,
    input  wire logic [`KEY_IDX_W-1:0] keyWrIdx,
    input  wire logic [`ADDR_W-1:0]    keyWrAddr,
    input  wire logic [7:0]            keyWrData,
    // user command
    input  wire logic                  cmdValid,
    input  wire eeprom_lock_pkg::cmd_t cmdKind,
    input  wire logic [`ADDR_W-1:0]    cmdAddr,
    input  wire logic [7:0]            cmdData,
    output logic                       cmdReady,
    output logic                       done,
    output logic [7:0]                 readData,
    // memory pins
    output logic [`ADDR_W-1:0]         memAddr,
    output logic                       chipEnN,
    output logic                       outEnN,
    output logic                       writeEnN,
    output logic [7:0]                 dqOut,
    output logic                       dqOeN,
    input  wire logic [7:0]            dqIn
);
    localparam int READ_WAIT = `READ_DELAY_US * `CLK_MHZ;
    localparam int GAP_CYC   = `PAGE_WINDOW_NS * `CLK_MHZ / 1000 / 2;
    localparam int CNT_W     = $clog2(WRITE_WAIT + PROG_WAIT + 2*GAP_CYC + 2);
    eeprom_lock_pkg::state_t state, next_state;
    logic [CNT_W-1:0]        cnt, next_cnt;
    logic [`KEY_IDX_W-1:0]   idx, next_idx;
    logic [`KEY_IDX_W-1:0]   keyLen, next_keyLen;
    logic                    withData, next_withData;
    logic                    dataPhase, next_dataPhase;
    logic                    isRead, next_isRead;
    logic [`ADDR_W-1:0]      uAddr, next_uAddr;
    logic [7:0]              uData, next_uData;
    logic [`ADDR_W-1:0]      next_memAddr;
    logic [7:0]              next_dqOut, next_readData;
    logic                    next_ce, next_oe, next_we, next_dqOeN;
    logic                    next_cmdReady, next_done;
    logic [7:0]              dqSync1, dqSync2;
    logic [22:0]             keyWord;
    // counter compare shared by every wait
    function automatic logic reached(input logic [CNT_W-1:0] c, input int n);
        return c >= CNT_W'(n);
    endfunction
    key_table #(.IDX_W(`KEY_IDX_W)) keys (
        .clk    (clk),
        .wrEn   (keyWrEn),
        .wrIdx  (keyWrIdx),
        .wrWord ({keyWrAddr, keyWrData}),
        .rdIdx  (next_idx), // read ahead so setup sees the entry of idx
        .rdWord (keyWord)
    );
    // two-stage synchroniser for the data pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dqSync1 <= 8'h00;
            dqSync2 <= 8'h00;
        end else begin
            dqSync1 <= dqIn;
            dqSync2 <= dqSync1;
        end
    end

    // sequencer next values
    always_comb begin
        next_state     = state;
        next_cnt       = cnt + 1'b1;
        next_idx       = idx;
        next_keyLen    = keyLen;
        next_withData  = withData;
        next_dataPhase = dataPhase;
        next_isRead    = isRead;
        next_uAddr     = uAddr;
        next_uData     = uData;
        next_memAddr   = memAddr;
        next_dqOut     = dqOut;
        next_readData  = readData;
        next_ce        = chipEnN;
        next_oe        = outEnN;
        next_we        = writeEnN;
        next_dqOeN     = dqOeN;
        next_cmdReady  = 1'b0;
        next_done      = 1'b0;
        case (state)
            eeprom_lock_pkg::ST_POWERUP: begin
                // no access until both power-up delays pass
                // the lock state is unknown, so nothing is assumed
                if (reached(cnt, WRITE_WAIT) && reached(cnt, READ_WAIT)) begin
                    next_state    = eeprom_lock_pkg::ST_IDLE;
                    next_cmdReady = 1'b1;
                end
            end
            eeprom_lock_pkg::ST_IDLE: begin
                next_cmdReady = 1'b1;
                next_cnt      = '0;
                if (cmdValid && cmdReady) begin
                    next_cmdReady  = 1'b0;
                    next_uAddr     = cmdAddr;
                    next_uData     = cmdData;
                    next_isRead    = cmdKind == eeprom_lock_pkg::CMD_READ;
                    next_withData  = cmdKind == eeprom_lock_pkg::CMD_WRITE;
                    next_dataPhase = 1'b0;
                    next_state     = eeprom_lock_pkg::ST_SETUP;
                    // keyed write: enable key then data
                    next_idx    = `ENABLE_KEY_BASE;
                    next_keyLen = `ENABLE_KEY_LEN;
                    if (cmdKind == eeprom_lock_pkg::CMD_UNLOCK) begin
                        next_idx    = `DISABLE_KEY_BASE;
                        next_keyLen = `DISABLE_KEY_LEN;
                    end
                end
            end
            eeprom_lock_pkg::ST_SETUP: begin
                // key word was read ahead, so it belongs to idx here
                next_ce = 1'b0;
                next_cnt = '0;
                if (isRead) begin
                    next_memAddr = uAddr;
                    next_oe      = 1'b0;
                    next_dqOeN   = 1'b1;
                    next_state   = eeprom_lock_pkg::ST_READ;
                end else begin
                    next_oe = 1'b1;
                    next_we = 1'b0;
                    next_dqOeN = 1'b0;
                    next_state = eeprom_lock_pkg::ST_STROBE;
                    if (dataPhase) begin
                        next_memAddr = uAddr;
                        next_dqOut   = uData;
                    end else begin
                        next_memAddr = keyWord[22:8];
                        next_dqOut   = keyWord[7:0];
                    end
                end
            end
            eeprom_lock_pkg::ST_STROBE: begin
                if (reached(cnt, `STROBE_CYCLES - 1)) begin
                    next_we    = 1'b1; // data latched on the rising edge
                    next_ce    = 1'b1;
                    next_cnt   = '0;
                    next_state = eeprom_lock_pkg::ST_GAP;
                end
            end
            eeprom_lock_pkg::ST_GAP: begin
                next_dqOeN = 1'b1;
                // bytes stay within the page-load window
                if (reached(cnt, 1)) begin
                    next_cnt = '0;
                    if (!dataPhase && idx + 1'b1 < keyLen) begin
                        next_idx   = idx + 1'b1;
                        next_state = eeprom_lock_pkg::ST_SETUP;
                    end else if (!dataPhase && withData) begin
                        // one data byte, never two pages
                        next_dataPhase = 1'b1;
                        next_state     = eeprom_lock_pkg::ST_SETUP;
                    end else begin
                        next_state = eeprom_lock_pkg::ST_PROGRAM;
                    end
                end
                if (reached(cnt, GAP_CYC)) begin
                    next_state = eeprom_lock_pkg::ST_PROGRAM;
                end
            end
            eeprom_lock_pkg::ST_READ: begin
                if (reached(cnt, `STROBE_CYCLES + 2)) begin
                    next_readData = dqSync2;
                    next_oe       = 1'b1;
                    next_ce       = 1'b1;
                    next_done     = 1'b1;
                    next_state    = eeprom_lock_pkg::ST_IDLE;
                end
            end
            eeprom_lock_pkg::ST_PROGRAM: begin
                // wait the full window, then the write cycle
                if (reached(cnt, 2 * GAP_CYC + PROG_WAIT)) begin
                    next_done  = 1'b1;
                    next_state = eeprom_lock_pkg::ST_IDLE;
                end
            end
            default: next_state = eeprom_lock_pkg::ST_POWERUP;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state     <= eeprom_lock_pkg::ST_POWERUP;
            cnt       <= '0;
            idx       <= '0;
            keyLen    <= '0;
            withData  <= 1'b0;
            dataPhase <= 1'b0;
            isRead    <= 1'b0;
            uAddr     <= '0;
            uData     <= 8'h00;
            memAddr   <= '0;
            dqOut     <= 8'h00;
            readData  <= 8'h00;
            chipEnN   <= 1'b1;
            outEnN    <= 1'b1;
            writeEnN  <= 1'b1;
            dqOeN     <= 1'b1;
            cmdReady  <= 1'b0;
            done      <= 1'b0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            idx       <= next_idx;
            keyLen    <= next_keyLen;
            withData  <= next_withData;
            dataPhase <= next_dataPhase;
            isRead    <= next_isRead;
            uAddr     <= next_uAddr;
            uData     <= next_uData;
            memAddr   <= next_memAddr;
            dqOut     <= next_dqOut;
            readData  <= next_readData;
            chipEnN   <= next_ce;
            outEnN    <= next_oe;
            writeEnN  <= next_we;
            dqOeN     <= next_dqOeN;
            cmdReady  <= next_cmdReady;
            done      <= next_done;
        end
    end

    // no write strobe in the first 8 cycles after reset release
    sequence powerUpWait;
        writeEnN [*8];
    endsequence
    property noEarlyWrite;
        @(posedge clk) disable iff (!rstn)
        $rose(rstn) |-> powerUpWait;
    endproperty
    power_write_gap_a: assert property (noEarlyWrite)
        else $error("write strobe during power-up");
    // read and write strobes never overlap
    bus_contention_a: assert property (
        @(posedge clk) disable iff (!rstn) !(outEnN == 1'b0 && writeEnN == 1'b0))
        else $error("read and write strobes overlap");
    // write strobe always ends within 4 cycles of its fall
    strobe_width_a: assert property (
        @(posedge clk) disable iff (!rstn)
        $fell(writeEnN) |-> ##[1:4] writeEnN)
        else $error("write strobe too long");
    // data driven whenever write is low
    data_drive_a: assert property (
        @(posedge clk) disable iff (!rstn) !writeEnN |-> !dqOeN)
        else $error("data not driven during write");
    // done pulses for one cycle
    done_pulse_a: assert property (
        @(posedge clk) disable iff (!rstn) done |=> !done)
        else $error("done held");
    // lock burst gives three strobes
    lock_start_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (cmdValid && cmdReady && cmdKind == eeprom_lock_pkg::CMD_LOCK)
        |=> keyLen == `ENABLE_KEY_LEN)
        else $error("lock key length wrong");
    // unlock burst gives six strobes
    unlock_start_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (cmdValid && cmdReady && cmdKind == eeprom_lock_pkg::CMD_UNLOCK)
        |=> keyLen == `DISABLE_KEY_LEN)
        else $error("unlock key length wrong");
    // chip select low while write strobe low
    chip_select_a: assert property (
        @(posedge clk) disable iff (!rstn) !writeEnN |-> !chipEnN)
        else $error("write without chip select");
endmodule // eeprom_lock_host
`default_nettype wire

// file: tb/eeprom_dev_model.sv
// behavioural eeprom with a keyed write lock, seen from its pins
`timescale 1ns/10ps
`default_nettype none
module eeprom_dev_model #(
    parameter logic [68:0]  EN_KEY  = '0,
    parameter logic [137:0] DIS_KEY = '0,
    parameter real          PUW_NS  = 3200.0,
    parameter real          WIN_NS  = 1000.0
) (
    // memory pins
    input  wire logic [14:0] memAddr,
    input  wire logic        chipEnN,
    input  wire logic        outEnN,
    input  wire logic        writeEnN,
    input  wire logic [7:0]  dqOut,
    input  wire logic        dqOeN,
    output var  logic [7:0]  dqIn
);
    logic [7:0]  mem [0:32767];
    logic        locked = 1'b0;  // no reset pin
    logic [14:0] bufA [$];
    logic [7:0]  bufD [$];
    realtime     lastT;
    int          earlyWrites = 0;
    int          burstLen = 0;
    wire         wr = !chipEnN && !writeEnN && outEnN;
    wire         rd = !chipEnN && !outEnN && writeEnN;

    // erased array, bus parked
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        dqIn = 8'h00;
    end

    // take one byte as the write strobe ends; early writes are dropped
    always @(negedge wr) begin
        if ($realtime > 0.0 && $realtime < PUW_NS) begin
            earlyWrites++;
        end else if ($realtime > 0.0) begin
            bufA.push_back(memAddr);
            bufD.push_back(dqOeN ? ~dqOut : dqOut);
            lastT = $realtime;
        end
    end

    // page-load timer: program once no byte came within the window
    initial forever begin
        #50;
        if (bufA.size() > 0 && $realtime - lastT >= WIN_NS) begin
            commit();
        end
    end

    // true when the first n bytes of the burst equal the key table
    function automatic bit keyHit(input logic [137:0] key, input int n);
        keyHit = bufA.size() >= n;
        for (int i = 0; i < n; i++) begin
            if (keyHit && {bufA[i], bufD[i]} != key[i*23 +: 23]) keyHit = 0;
        end
    endfunction

    // internal write cycle for the collected burst
    task automatic commit();
        bit same = 1'b1;
        burstLen = bufA.size();
        foreach (bufA[i]) same &= (bufA[i][14:6] == bufA[0][14:6]);
        if (burstLen == 6 && keyHit(DIS_KEY, 6)) begin
            locked = 1'b0;
        end else if (keyHit({69'h0, EN_KEY}, 3)) begin
            locked = 1'b1;
            for (int i = 3; i < burstLen; i++) begin
                mem[bufA[i]] = bufD[i];
            end
        end else if (!locked && same) begin
            foreach (bufA[i]) mem[bufA[i]] = bufD[i];
        end
        bufA.delete();
        bufD.delete();
    endtask

    // read data; once released the bus shows the inverse of its last value
    always @(rd, memAddr) dqIn = rd ? mem[memAddr] : ~dqIn;
endmodule  // eeprom_dev_model
`default_nettype wire

// file: tb/eeprom_software_write_lock_tb.sv
// self-checking bench for the eeprom write lock host
`include "eeprom_lock_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    err_total++; $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
    end end
module eeprom_software_write_lock_tb;
    localparam int WW = 50;
    localparam logic [68:0] EN_KEY = {15'h00C0, 8'h33, 15'h0080, 8'h22,
                                      15'h0040, 8'h11};
    localparam logic [137:0] DIS_KEY = {15'h0240, 8'h46, 15'h0200, 8'h45,
        15'h01C0, 8'h44, 15'h0180, 8'h43, 15'h0140, 8'h42, 15'h0100, 8'h41};
    logic                  clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  keyWrEn = 1'b0;
    logic [2:0]            keyWrIdx = 3'h0;
    logic [14:0]           keyWrAddr = 15'h0000;
    logic [7:0]            keyWrData = 8'h00;
    logic                  cmdValid = 1'b0;
    eeprom_lock_pkg::cmd_t cmdKind = eeprom_lock_pkg::CMD_READ;
    logic [14:0]           cmdAddr = 15'h0000;
    logic [7:0]            cmdData = 8'h00;
    logic                  cmdReady, done, chipEnN, outEnN, writeEnN, dqOeN;
    logic [7:0]            readData, dqOut, dqIn, q;
    logic [14:0]           memAddr;
    int                    err_total = 0;
    int                    num_checks = 0;
    int                    cyc = 0;

    eeprom_lock_host #(.LOW_VOLT(1'b0), .WRITE_WAIT(WW), .PROG_WAIT(50)) dut (
        .clk(clk), .rstn(rstn), .keyWrEn(keyWrEn), .keyWrIdx(keyWrIdx),
        .keyWrAddr(keyWrAddr), .keyWrData(keyWrData), .cmdValid(cmdValid),
        .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .cmdReady(cmdReady), .done(done), .readData(readData),
        .memAddr(memAddr), .chipEnN(chipEnN), .outEnN(outEnN),
        .writeEnN(writeEnN), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn));

    eeprom_dev_model #(.EN_KEY(EN_KEY), .DIS_KEY(DIS_KEY)) mdl (
        .memAddr(memAddr), .chipEnN(chipEnN), .outEnN(outEnN),
        .writeEnN(writeEnN), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn));

    // 20 MHz clock
    initial forever #25 clk = ~clk;

    // hang guard: a full run takes about 8500 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    // counts, verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // load n key entries, strobe held across consecutive entries
    task automatic load_key(input logic [137:0] key, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            keyWrEn = 1'b1;
            keyWrIdx = i[2:0];
            {keyWrAddr, keyWrData} = key[i*23 +: 23];
        end
        @(posedge clk);
        #1;
        keyWrEn = 1'b0;
    endtask

    // one command: hold the request until taken, then wait for done
    task automatic run_cmd(input eeprom_lock_pkg::cmd_t k,
                           input logic [14:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        #1;
        cmdValid = 1'b1;
        cmdKind = k;
        cmdAddr = a;
        cmdData = d;
        while (cmdReady !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);  // taken here: ready stood high before this edge
        #1;
        cmdValid = 1'b0;
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        q = readData;
        `CHK("done", 1'b1, done)
    endtask

    // reset, then no strobe and no ready before the write delay
    task automatic test_powerup();
        int n = 0;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        while (cmdReady !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("ready delay", 1'b1, (n >= WW - 1) && (n <= WW + 4))
        `CHK("no early write", 0, mdl.earlyWrites)
        `CHK("shipped unlocked", 1'b0, mdl.locked)
        $display("test_powerup done");
    endtask

    // keyed write: data and lock in one burst, data readable
    task automatic test_keyed_write();
        load_key(EN_KEY, 3);
        run_cmd(eeprom_lock_pkg::CMD_WRITE, 15'h1234, 8'hA5);
        `CHK("write burst", 4, mdl.burstLen)
        `CHK("lock set", 1'b1, mdl.locked)
        run_cmd(eeprom_lock_pkg::CMD_READ, 15'h1234, 8'h00);
        `CHK("written byte", 8'hA5, q)
        $display("test_keyed_write done");
    endtask

    // wrong key while locked: memory untouched
    task automatic test_bad_key();
        load_key({69'h0, EN_KEY ^ 69'h1}, 3);
        run_cmd(eeprom_lock_pkg::CMD_WRITE, 15'h1240, 8'h3C);
        run_cmd(eeprom_lock_pkg::CMD_READ, 15'h1240, 8'h00);
        `CHK("guarded byte", 8'hFF, q)
        `CHK("still locked", 1'b1, mdl.locked)
        $display("test_bad_key done");
    endtask

    // six-byte unlock, then three-byte lock
    task automatic test_unlock_lock();
        load_key(DIS_KEY, 6);
        run_cmd(eeprom_lock_pkg::CMD_UNLOCK, 15'h0000, 8'h00);
        `CHK("unlock burst", 6, mdl.burstLen)
        `CHK("unlocked", 1'b0, mdl.locked)
        load_key(EN_KEY, 3);
        run_cmd(eeprom_lock_pkg::CMD_LOCK, 15'h0000, 8'h00);
        `CHK("lock burst", 3, mdl.burstLen)
        `CHK("relocked", 1'b1, mdl.locked)
        run_cmd(eeprom_lock_pkg::CMD_READ, 15'h1234, 8'h00);
        `CHK("kept byte", 8'hA5, q)
        $display("test_unlock_lock done");
    endtask

    // main sequence
    initial begin
        test_powerup();
        test_keyed_write();
        test_bad_key();
        test_unlock_lock();
        test_done();
    end
endmodule  // eeprom_software_write_lock_tb
`default_nettype wire
